// File: verilog/ahb_device.sv
// Device end: strap latch, strobe synchroniser, register file, buffer.
// Assumes straps stable around reset release; host_port_clock is mclk.
module ahb_device #(
    parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary value
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [15:0] strap_in,
    ahb_if.dev bus,
    output logic [15:0] strap_cfg,
    output logic port_enabled,
    output logic alt_variant
);
    typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_DONE} ahb_dst_e;
    typedef struct packed {
        logic init_done;
        logic [15:0] straps;
        logic [1:0] rd_sync;
        logic [1:0] wr_sync;
        logic tick_div;
        ahb_dst_e st;
        logic [3:0] arb_cnt;
        logic is_read;
        logic [7:0] misc;
        logic [15:0] rdata;
        logic drive;
        logic waiting;
        logic wait_oe;
        logic ready_lvl;
        logic enabled;
    } ahb_dev_s;

    ahb_dev_s q, d;
    // Buffer model is small; upper address bits alias onto it
    logic [15:0] mem [ahb_pkg::MEM_WORDS];
    logic [7:0] regs [ahb_pkg::NUM_REGS];
    logic mem_we;
    logic [1:0] lanes_we;
    logic [15:0] wdata;
    logic [9:0] mem_idx;
    logic [3:0] reg_idx;
    logic reg_we;
    logic reg_lane;
    logic [7:0] reg_byte;

    // Refuse geometries that the fixed index slices cannot serve
    if (ahb_pkg::MEM_WORDS != 1024) begin
        $error("buffer model needs exactly 1024 words");
    end
    if (ahb_pkg::NUM_REGS != 16) begin
        $error("register file needs exactly 16 entries");
    end
    if (ahb_pkg::ADDR_W != 21 || ahb_pkg::DATA_W != 16 ||
        ahb_pkg::STRAP_W != 16) begin
        $error("port needs 21 address, 16 data and 16 strap bits");
    end

    function automatic logic [15:0] swap16(input logic [15:0] v,
                                            input logic little);
        swap16 = little ? v : {v[7:0], v[15:8]};
    endfunction

    wire logic little = q.straps[ahb_pkg::BYTE_ORDER_BIT];
    wire logic mode_ok = q.straps[ahb_pkg::MODE_LO +: 3]
        == ahb_pkg::MODE_STROBE16;
    wire logic cs_act = !bus.cs_n && mode_ok && q.init_done;
    // Halved port clock is an enable pulse, not a second clock
    wire logic tick = !q.straps[ahb_pkg::CLKDIV_BIT] || q.tick_div;
    // Lock hides registers 2 to 15 only; ID, misc and the buffer stay reachable
    wire logic locked = q.misc[ahb_pkg::MISC_LOCK_BIT];
    // Byte enables from high enable and A0
    wire logic a0 = bus.host_address_in[0];
    wire logic [1:0] lanes = {!bus.high_byte_enable_n, !a0};

    assign mem_idx = bus.host_address_in[10:1]; // wraps in model
    assign reg_idx = bus.host_address_in[3:0];
    assign wdata = swap16(bus.host_data_out, little);
    // A register byte rides the lane of its own address
    assign reg_lane = a0 ? lanes[1] : lanes[0];
    assign reg_byte = a0 ? wdata[15:8] : wdata[7:0];

    always_comb begin
        d = q;
        mem_we = 1'b0;
        reg_we = 1'b0;
        lanes_we = lanes;
        // Strap capture on the first edge after release
        if (!q.init_done) begin
            d.init_done = 1'b1;
            d.straps = strap_in;
        end
        // Two-flop synchronisers; only stage 1 feeds the state machine
        // so an unsettled stage 0 never reaches a decision
        d.rd_sync = {q.rd_sync[0], cs_act && !bus.rd_n};
        d.wr_sync = {q.wr_sync[0], cs_act && !bus.write_strobe_n};
        d.tick_div = !q.tick_div;
        unique case (q.st)
            ST_IDLE: begin
                if (q.rd_sync[1] || q.wr_sync[1]) begin
                    d.st = ST_ARB;
                    d.is_read = q.rd_sync[1];
                    d.arb_cnt = ahb_pkg::ARB_TICKS;
                    d.waiting = 1'b1;
                end
            end
            ST_ARB: begin
                // Refresh contention modelled as a fixed tick count
                if (tick) begin
                    if (q.arb_cnt != 4'h0) begin
                        d.arb_cnt = q.arb_cnt - 4'h1;
                    end else begin
                        d.st = ST_DONE;
                        d.waiting = 1'b0;
                        if (q.is_read) begin
                            if (bus.mem_reg_sel) begin
                                d.rdata = swap16(mem[mem_idx], little);
                            end else if (locked && reg_idx > 4'h1) begin
                                d.rdata = 16'h0000;
                            end else if (reg_idx == 4'h0) begin
                                // Byte on both lanes, readable from either
                                d.rdata = {ID_VALUE, ID_VALUE};
                            end else if (reg_idx == 4'h1) begin
                                d.rdata = {q.misc, q.misc};
                            end else begin
                                d.rdata = {regs[reg_idx], regs[reg_idx]};
                            end
                        end else if (bus.mem_reg_sel) begin
                            mem_we = 1'b1;
                        end else if (reg_idx == 4'h1) begin
                            d.misc = reg_lane ? reg_byte : q.misc;
                        end else if (!locked && reg_idx != 4'h0) begin
                            reg_we = reg_lane;
                        end
                    end
                end
            end
            ST_DONE: begin
                // Hold until the host drops its strobe
                if (!q.rd_sync[1] && !q.wr_sync[1]) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // Data stands from the edge wait drops until the strobe goes,
        // so the host never samples a released bus
        d.drive = cs_act && !bus.rd_n && d.st == ST_DONE && q.is_read;
        // Float wait when deselected unless strap says always
        d.wait_oe = !(q.straps[ahb_pkg::WAIT_DRIVE_BIT] || cs_act);
        // Pin levels registered so every output leaves a flip-flop
        d.ready_lvl = d.straps[ahb_pkg::WAIT_POL_BIT] ? d.waiting :
            !d.waiting;
        d.enabled = d.init_done &&
            d.straps[ahb_pkg::MODE_LO +: 3] == ahb_pkg::MODE_STROBE16;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{init_done: 1'b0, straps: 16'h0000, rd_sync: 2'h0,
                   wr_sync: 2'h0, tick_div: 1'b0, st: ST_IDLE,
                   arb_cnt: 4'h0, is_read: 1'b0,
                   misc: ahb_pkg::MISC_RESET,
                   rdata: 16'h0000, drive: 1'b0, waiting: 1'b0,
                   wait_oe: 1'b1, ready_lvl: 1'b1, enabled: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Storage arrays kept out of the state struct for inference
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            if (lanes_we[0]) mem[mem_idx][7:0] <= wdata[7:0];
            if (lanes_we[1]) mem[mem_idx][15:8] <= wdata[15:8];
        end
        if (reg_we) begin
            regs[reg_idx] <= reg_byte;
        end
    end

    assign bus.dev_data_out = q.rdata;
    assign bus.dev_data_oe_n = !q.drive;
    // Wait asserted level per polarity strap
    assign bus.host_ready_line = q.ready_lvl;
    assign bus.ready_oe_n = q.wait_oe;
    assign strap_cfg = q.straps;
    assign port_enabled = q.enabled;
    assign alt_variant = q.straps[ahb_pkg::VARIANT_BIT];
endmodule

// File: verilog/ahb_pkg.sv
// Constants shared by both ends of the asynchronous-strobe host port.
// Assumes one clock, mclk at 40 MHz, and asynchronous active-low reset.
package ahb_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int STRAP_W = 16;
    // Strap field positions
    localparam int MODE_LO = 1;
    localparam int BYTE_ORDER_BIT = 4;
    localparam int WAIT_POL_BIT = 5;
    localparam int VARIANT_BIT = 11;
    localparam int CLKDIV_BIT = 12;
    localparam int WAIT_DRIVE_BIT = 15;
    localparam logic [2:0] MODE_STROBE16 = 3'h5;
    // Register map
    localparam logic [7:0] REG_ID_OFS = 8'h00;
    localparam logic [7:0] REG_MISC_OFS = 8'h01;
    localparam int MISC_LOCK_BIT = 7;
    localparam logic [7:0] MISC_RESET = 8'h80;
    localparam int NUM_REGS = 16;
    // Buffer arbitration delay in host-port ticks
    localparam logic [3:0] ARB_TICKS = 4'h3;
    localparam int MEM_WORDS = 1024;
    // Host watchdog while waiting on the ready line
    localparam logic [7:0] HOST_TIMEOUT = 8'hff;
endpackage

// File: verilog/ahb_if.sv
// Pin bundle joining the host end to the device end of the strobe port.
// Assumes the testbench resolves the data bus from the two enables.
interface ahb_if;
    logic [20:0] host_address_in;
    logic mem_reg_sel;
    logic cs_n;
    logic rd_n;
    logic write_strobe_n;
    logic high_byte_enable_n;
    logic bus_start_n;
    logic rd_wr_n;
    logic [15:0] dev_data_out;
    logic dev_data_oe_n;
    logic [15:0] host_data_out;
    logic host_data_oe_n;
    logic [15:0] host_data_in;
    logic host_ready_line;
    logic ready_oe_n;
    modport dev (
        input host_address_in, mem_reg_sel, cs_n, rd_n, write_strobe_n,
        input high_byte_enable_n, bus_start_n, rd_wr_n, host_data_out,
        input host_data_oe_n,
        output dev_data_out, dev_data_oe_n, host_ready_line, ready_oe_n
    );
    modport host (
        output host_address_in, mem_reg_sel, cs_n, rd_n, write_strobe_n,
        output high_byte_enable_n, bus_start_n, rd_wr_n, host_data_out,
        output host_data_oe_n,
        input host_data_in, host_ready_line, ready_oe_n
    );
endinterface

// File: verilog/ahb_host.sv
// Host end: runs one read or write per request on the strobe port.
// Assumes the device's wait polarity is supplied as a static input.
module ahb_host (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic req,
    input wire logic req_write,
    input wire logic req_mem,
    input wire logic [20:0] req_addr,
    input wire logic req_hi_n,
    input wire logic [15:0] req_wdata,
    input wire logic wait_active_high,
    ahb_if.host bus,
    output logic busy,
    output logic done,
    output logic timeout,
    output logic [15:0] rdata
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_END} ahb_hst_e;
    typedef struct packed {
        ahb_hst_e st;
        logic [20:0] addr;
        logic mem;
        logic write;
        logic hi_n;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic cs_n;
        logic strobe;
        logic [7:0] guard;
        logic seen_wait;
        logic done;
        logic timeout;
    } ahb_host_s;

    ahb_host_s q, d;
    // Wait seen only while the device drives the line
    wire logic wait_now = !bus.ready_oe_n &&
        (bus.host_ready_line == wait_active_high);

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.timeout = 1'b0;
        unique case (q.st)
            H_IDLE: begin
                if (req) begin
                    d.addr = req_addr;
                    d.mem = req_mem;
                    d.write = req_write;
                    d.hi_n = req_hi_n;
                    d.wdata = req_wdata;
                    d.cs_n = 1'b0;
                    d.st = H_SETUP;
                end
            end
            H_SETUP: begin
                d.strobe = 1'b1;
                d.guard = 8'h00;
                d.seen_wait = 1'b0;
                d.st = H_STROBE;
            end
            H_STROBE: begin
                // Extend the cycle while wait is asserted
                d.guard = q.guard + 8'h01;
                if (wait_now) begin
                    d.seen_wait = 1'b1;
                end
                if (q.seen_wait && !wait_now) begin
                    d.rdata = bus.host_data_in;
                    d.strobe = 1'b0;
                    d.st = H_END;
                end else if (q.guard == ahb_pkg::HOST_TIMEOUT) begin
                    // Give up rather than hang on a dead device
                    d.strobe = 1'b0;
                    d.timeout = 1'b1;
                    d.st = H_END;
                end
            end
            H_END: begin
                d.cs_n = 1'b1;
                d.done = !q.timeout;
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{st: H_IDLE, addr: 21'h00_0000, mem: 1'b0, write: 1'b0,
                   hi_n: 1'b1, wdata: 16'h0000, rdata: 16'h0000,
                   cs_n: 1'b1, strobe: 1'b0, guard: 8'h00,
                   seen_wait: 1'b0, done: 1'b0, timeout: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign bus.host_address_in = q.addr;
    assign bus.mem_reg_sel = q.mem;
    assign bus.cs_n = q.cs_n;
    assign bus.rd_n = !(q.strobe && !q.write);
    assign bus.write_strobe_n = !(q.strobe && q.write);
    assign bus.high_byte_enable_n = q.hi_n;
    assign bus.bus_start_n = 1'b1;
    assign bus.rd_wr_n = 1'b1;
    assign bus.host_data_out = q.wdata;
    assign bus.host_data_oe_n = !(q.write && !q.cs_n);
    assign busy = q.st != H_IDLE;
    assign done = q.done;
    assign timeout = q.timeout;
    assign rdata = q.rdata;
endmodule

// File: verif/ahb_properties.sv
// Checker on the strobe port wires between the host and device ends.
// Assumes the bench places it beside the interface instance.
module ahb_properties (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wait_active_high,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic write_strobe_n,
    input wire logic bus_start_n,
    input wire logic rd_wr_n,
    input wire logic [15:0] dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic host_ready_line,
    input wire logic ready_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic wait_on;
    logic strobe;
    assign wait_on = !ready_oe_n && (host_ready_line == wait_active_high);
    assign strobe = !cs_n && !(rd_n && write_strobe_n);
    a_strobe_needs_cs: assert property (
        (!rd_n || !write_strobe_n) |-> !cs_n)
        else $error("strobe without chip select");
    a_sync_delay: assert property (
        $rose(strobe) |-> !wait_on ##1 !wait_on)
        else $error("wait before strobe synchronised");
    a_wait_follows: assert property (
        $rose(strobe) |-> ##[2:6] wait_on)
        else $error("wait not raised after strobe");
    a_wait_bounded: assert property (
        $rose(wait_on) |-> ##[1:16] !wait_on)
        else $error("wait held too long");
    a_hold_strobe: assert property (
        wait_on && strobe |=> strobe)
        else $error("strobe dropped during wait");
    a_read_release: assert property (
        $rose(rd_n) |-> ##[0:3] dev_data_oe_n)
        else $error("data bus not released");
    a_no_drive_write: assert property (
        !write_strobe_n |-> dev_data_oe_n)
        else $error("device drives bus during write");
    a_data_steady: assert property (
        !dev_data_oe_n && !$past(dev_data_oe_n) |-> $stable(dev_data_out))
        else $error("read data changed while driven");
    a_idle_no_wait: assert property (
        cs_n [*4] |-> !wait_on)
        else $error("wait while deselected");
    a_pins_tied: assert property (
        bus_start_n && rd_wr_n)
        else $error("unused pins not held high");
endmodule

// File: verif/tb_async_host_bus_slave_port.sv
// Bench joining host and device ends across the strobe port interface.
// Assumes mclk at 40 MHz and straps applied while reset is held.
module tb_async_host_bus_slave_port;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
        n_fail++; $display("ERROR %0t mismatch %h %h", $time, a, b); end end
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] strap_in = 16'h983a;
    logic req = 1'b0;
    logic req_write = 1'b0;
    logic req_mem = 1'b0;
    logic req_hi_n = 1'b1;
    logic wah = 1'b1;
    logic [20:0] req_addr = 21'h0_0000;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] pat = 16'h0000;
    logic [15:0] strap_cfg, rdata;
    logic port_enabled, alt_variant, busy, done, timeout;
    int n_fail = 0;
    int compares = 0;
    int lat = 0;
    int lat_div = 0;
    ahb_if bus ();
    always #12.5 mclk = ~mclk;
    // Released bus shows pat, which negates itself each edge and so stays at 0000
    always @(posedge mclk) pat <= ~pat + 16'h0001;
    assign bus.host_data_in = !bus.dev_data_oe_n ? bus.dev_data_out :
        !bus.host_data_oe_n ? bus.host_data_out : pat;
    ahb_device #(.ID_VALUE(8'h5a)) u_ahb_device (.mclk(mclk),
        .arst_n(arst_n), .strap_in(strap_in), .bus(bus.dev),
        .strap_cfg(strap_cfg), .port_enabled(port_enabled),
        .alt_variant(alt_variant));
    ahb_host u_ahb_host (.mclk(mclk), .arst_n(arst_n), .req(req),
        .req_write(req_write), .req_mem(req_mem), .req_addr(req_addr),
        .req_hi_n(req_hi_n), .req_wdata(req_wdata),
        .wait_active_high(wah), .bus(bus.host), .busy(busy), .done(done),
        .timeout(timeout), .rdata(rdata));
    ahb_properties u_ahb_properties (.mclk(mclk), .arst_n(arst_n),
        .wait_active_high(wah), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
        .write_strobe_n(bus.write_strobe_n), .bus_start_n(bus.bus_start_n),
        .rd_wr_n(bus.rd_wr_n), .dev_data_out(bus.dev_data_out),
        .dev_data_oe_n(bus.dev_data_oe_n),
        .host_ready_line(bus.host_ready_line), .ready_oe_n(bus.ready_oe_n));
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [15:0] s);
        @(posedge mclk);
        #2 arst_n = 1'b0;
        strap_in = s;
        wah = s[5];
        repeat (12) @(posedge mclk);
        #2 arst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #2;
    endtask
    task automatic acc(input logic w, input logic m, input logic [20:0] a,
            input logic hn, input logic [15:0] d);
        int i;
        req_write = w;
        req_mem = m;
        req_addr = a;
        req_hi_n = hn;
        req_wdata = d;
        req = 1'b1;
        @(posedge mclk);
        #2 req = 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++) begin
            @(posedge mclk);
            #2;
        end
        lat = i;
        if (done !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t access never completed", $time);
            end_sim();
        end
        `CHK(timeout, 1'b0)
        `CHK(busy, 1'b0)
        @(posedge mclk);
        #2;
    endtask
    task automatic s_straps();
        `CHK(strap_cfg, 16'h983a)
        `CHK(port_enabled, 1'b1)
        `CHK(alt_variant, 1'b1)
        `CHK(bus.ready_oe_n, 1'b0)
        `CHK(bus.host_ready_line, 1'b0)
        strap_in = 16'h0000;
        repeat (3) @(posedge mclk);
        #2;
        `CHK(strap_cfg, 16'h983a)
    endtask
    task automatic s_lock();
        acc(1'b0, 1'b0, 21'h0_0001, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h80)
        acc(1'b1, 1'b0, 21'h0_0002, 1'b1, 16'h003c);
        acc(1'b0, 1'b0, 21'h0_0002, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h00)
        acc(1'b1, 1'b0, 21'h0_0000, 1'b1, 16'h00ff);
        acc(1'b0, 1'b0, 21'h0_0000, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h5a)
        // Odd register byte travels on the high lane
        acc(1'b1, 1'b0, 21'h0_0001, 1'b0, 16'h0000);
        acc(1'b1, 1'b0, 21'h0_0002, 1'b1, 16'h003c);
        acc(1'b0, 1'b0, 21'h0_0002, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h3c)
    endtask
    task automatic s_mem();
        acc(1'b1, 1'b1, 21'h0_0010, 1'b0, 16'h1234);
        lat_div = lat;
        acc(1'b1, 1'b1, 21'h0_0011, 1'b0, 16'hab00);
        acc(1'b1, 1'b1, 21'h0_0020, 1'b1, 16'h0056);
        acc(1'b0, 1'b1, 21'h0_0010, 1'b0, 16'h0000);
        `CHK(rdata, 16'hab34)
        acc(1'b0, 1'b1, 21'h0_0020, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h56)
        acc(1'b0, 1'b1, 21'h1f_f810, 1'b0, 16'h0000);
        `CHK(rdata, 16'hab34)
        `CHK(bus.dev_data_oe_n, 1'b1)
        acc(1'b0, 1'b0, 21'h0_0010, 1'b1, 16'h0000);
        `CHK(rdata[7:0], 8'h5a)
    endtask
    task automatic s_big();
        `CHK(alt_variant, 1'b0)
        `CHK(bus.ready_oe_n, 1'b1)
        `CHK(bus.host_ready_line, 1'b1)
        // Active-low wait: host completes only if polarity follows strap
        acc(1'b1, 1'b1, 21'h0_0030, 1'b0, 16'h1234);
        `CHK(lat_div > lat, 1'b1)
        acc(1'b0, 1'b1, 21'h0_0030, 1'b0, 16'h0000);
        `CHK(rdata, 16'h1234)
        // Word stored little-endian earlier now reads byte-swapped
        acc(1'b0, 1'b1, 21'h0_0010, 1'b0, 16'h0000);
        `CHK(rdata, 16'h34ab)
        `CHK(bus.ready_oe_n, 1'b1)
    endtask
    initial begin
        do_reset(16'h983a);
        s_straps();
        s_lock();
        s_mem();
        do_reset(16'h000a);
        s_big();
        do_reset(16'h0004);
        `CHK(port_enabled, 1'b0)
        end_sim();
    end
endmodule
